//--- logic/nvm_pkg.sv
// Package: constants, types and state encoding for the nonvolatile access controller
package nvm_pkg;
    localparam int DATA_W      = 8;                // Byte lane width
    localparam int PROG_W      = 14;               // Program word width
    localparam int PADDR_W     = 13;               // Program word address width
    localparam int DADDR_W     = 8;                // Data byte address width
    localparam int KEY_W       = 8;                // Unlock key width
    localparam logic [7:0] KEY_FIRST  = 8'h55;     // First unlock key
    localparam logic [7:0] KEY_SECOND = 8'haa;     // Second unlock key
    localparam logic [7:0] ZERO_BYTE  = 8'h00;     // Read value of holes and unlock reg
    localparam int CLK_MHZ     = 50;               // Core clock rate
    localparam int WRITE_US    = 4;                // Self-timed write/erase time
    localparam int WRITE_CYC   = WRITE_US * CLK_MHZ; // Write/erase cycles
    localparam int READ_CYC    = 2;                // Read latency cycles
    localparam int CNT_W       = 16;               // Timer width
    localparam int BLK_ERASE   = 32;               // Words per erase block
    localparam int BLK_WRITE   = 4;                // Words per write block

    // Controller states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } nvm_state_e;

    // Unlock sequence progress
    typedef enum logic [1:0] {
        UL_NONE  = 2'b00,
        UL_ONE   = 2'b01,
        UL_OPEN  = 2'b10
    } unlock_e;

    // Software write strobes, grouped
    typedef struct packed {
        logic                 addr_low_we;
        logic                 addr_high_we;
        logic                 data_low_we;
        logic                 data_high_we;
        logic                 unlock_we;
        logic                 ctrl_we;
        logic [DATA_W-1:0]    wdata;
    } sw_write_s;

    // Control byte fields
    typedef struct packed {
        logic program_space_select;
        logic write_allow;
        logic erase_select;
        logic write_go;
        logic read_go;
    } ctrl_fields_s;
endpackage

//--- logic/nvm_self_access_controller.sv
// Nonvolatile self-access controller: data EEPROM and program flash sequencing
//
// Summary of operation
// - Data access uses low data/low address
// - Small variant data 80h-FFh reads 00h
// - Write to unimplemented byte: pump off
// - Program access uses 14-bit data, 13-bit address
// - Program address wraps above implemented range
// - Byte write erases then programs automatically
// - Word reads; 32-word erase, 4-word writes
// - Internal timer times writes; internal pump
// - Code protection keeps core access; block protect
// - Code protection refuses external programmer access
// - Upper address bits beyond 13 are stored but unused
// - Space select resets to data memory
// - Read/write triggers set-only, hardware cleared
// - Writes only while write-allow set
// - Interrupted write sets abort flag, keeps regs
// - Write-done flag set by hardware, software clears
// - Unlock register stores nothing, reads zero
`timescale 1ns/10ps
`default_nettype none
module nvm_self_access_controller
    import nvm_pkg::*;
#(
    parameter int DATA_BYTES  = 128,               // 128 or 256 data bytes
    parameter int PROG_WORDS  = 1024,              // 1024 or 2048 program words
    parameter int WRITE_TICKS = nvm_pkg::WRITE_CYC // Shortenable write time
) (
    input  wire logic                      clk_i,
    input  wire logic                      srst_i,
    input  wire logic                      ext_reset_i,       // Pin or watchdog reset
    input  wire nvm_pkg::sw_write_s        sw_i,
    input  wire logic                      flag_clear_i,      // Software clears done flag
    input  wire logic                      abort_clear_i,     // Software clears abort flag
    input  wire logic                      code_protect_i,
    input  wire logic [7:0]                block_protect_i,   // One bit per 256-word region
    input  wire logic                      prog_access_i,     // External programmer request
    input  wire logic [nvm_pkg::PROG_W-1:0] prog_rdata_i,     // Program array read word
    input  wire logic [nvm_pkg::DATA_W-1:0] data_rdata_i,     // Data array read byte
    output logic [nvm_pkg::DATA_W-1:0]     nvm_data_low_o,
    output logic [nvm_pkg::DATA_W-1:0]     nvm_data_high_o,
    output logic [nvm_pkg::DATA_W-1:0]     nvm_addr_low_o,
    output logic [nvm_pkg::DATA_W-1:0]     nvm_addr_high_o,
    output logic [nvm_pkg::DATA_W-1:0]     nvm_control_o,
    output logic [nvm_pkg::DATA_W-1:0]     nvm_unlock_o,
    output logic                           write_done_flag_o,
    output logic                           write_abort_flag_o,
    output logic                           pump_on_o,         // Charge pump enable
    output logic                           array_rd_o,        // Array read strobe level
    output logic                           prog_grant_o       // External programmer allowed
);
    import nvm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        nvm_state_e             st;
        unlock_e                ul;
        logic [CNT_W-1:0]       cnt;
        logic [DATA_W-1:0]      dlo;
        logic [DATA_W-1:0]      dhi;
        logic [DATA_W-1:0]      alo;
        logic [DATA_W-1:0]      ahi;
        ctrl_fields_s           ctl;
        logic                   done;
        logic                   abort;
        logic                   pump;
        logic                   rd;
        logic                   grant;
    } state_s;

    state_s s_q;   // Registered state
    state_s s_d;   // Next state

    localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WRITE_TICKS - 1); // Timer end
    localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(READ_CYC - 1);    // Read end

    // Implemented data location check
    function automatic logic data_hit(input logic [DATA_W-1:0] a);
        data_hit = (int'(a) < DATA_BYTES);
    endfunction

    // Program word address, wrapped to the implemented size
    function automatic logic [PADDR_W-1:0] prog_addr(input logic [DATA_W-1:0] hi,
                                                     input logic [DATA_W-1:0] lo);
        logic [PADDR_W-1:0] full;
        full = {hi[PADDR_W-DATA_W-1:0], lo};
        prog_addr = full & PADDR_W'(PROG_WORDS - 1);
    endfunction

    logic [PADDR_W-1:0] paddr;      // Current program address
    logic               wr_allowed; // Block protection lets this write through
    assign paddr = prog_addr(s_q.ahi, s_q.alo);
    // Region index is taken after the wrap, so an alias above the array
    // is guarded by the region that it really lands in
    assign wr_allowed = !s_q.ctl.program_space_select
                        || !block_protect_i[paddr[DATA_W+2:DATA_W] & 3'(PROG_WORDS/256 - 1)];

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.rd = 1'b0;
        // Core always keeps its own access; external programmer blocked under code protection
        s_d.grant = !code_protect_i && prog_access_i;
        // Address and data registers
        if (sw_i.addr_low_we && s_q.st != ST_WRITE) begin
            s_d.alo = sw_i.wdata;
        end
        if (sw_i.addr_high_we && s_q.st != ST_WRITE) begin
            s_d.ahi = sw_i.wdata;
        end
        if (sw_i.data_low_we && s_q.st != ST_WRITE) begin
            s_d.dlo = sw_i.wdata;
        end
        if (sw_i.data_high_we && s_q.st != ST_WRITE) begin
            s_d.dhi = sw_i.wdata & 8'h3f;
        end
        // Unlock sequence: any other write breaks it
        if (sw_i.unlock_we) begin
            if (sw_i.wdata == KEY_FIRST) begin
                s_d.ul = UL_ONE;
            end else if (sw_i.wdata == KEY_SECOND && s_q.ul == UL_ONE) begin
                s_d.ul = UL_OPEN;
            end else begin
                s_d.ul = UL_NONE;
            end
        end else if (sw_i.addr_low_we || sw_i.addr_high_we || sw_i.data_low_we
                     || sw_i.data_high_we) begin
            s_d.ul = UL_NONE;
        end
        // Control writes: triggers are set-only
        if (sw_i.ctrl_we) begin
            s_d.ul = UL_NONE;
            if (s_q.st == ST_IDLE) begin
                s_d.ctl.program_space_select = sw_i.wdata[7];
                s_d.ctl.erase_select = sw_i.wdata[4];
            end
            s_d.ctl.write_allow = sw_i.wdata[2];
            if (s_q.st == ST_IDLE && sw_i.wdata[0]) begin
                s_d.ctl.read_go = 1'b1;
                s_d.st = ST_READ;
                s_d.cnt = '0;
            end else if (s_q.st == ST_IDLE && sw_i.wdata[1] && sw_i.wdata[2]
                         && s_q.ctl.write_allow && s_q.ul == UL_OPEN) begin
                s_d.ctl.write_go = 1'b1;
                s_d.st = ST_WRITE;
                s_d.cnt = '0;
            end
        end
        // Sticky flags: set wins over clear
        if (flag_clear_i) begin
            s_d.done = 1'b0;
        end
        if (abort_clear_i) begin
            s_d.abort = 1'b0;
        end
        case (s_q.st)
            ST_IDLE: begin
                s_d.pump = 1'b0;
            end
            ST_READ: begin
                s_d.rd = 1'b1;
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt == RD_LAST) begin
                    // Load byte or word, then release trigger
                    if (s_q.ctl.program_space_select) begin
                        s_d.dlo = prog_rdata_i[DATA_W-1:0];
                        s_d.dhi = {2'b00, prog_rdata_i[PROG_W-1:DATA_W]};
                    end else if (data_hit(s_q.alo)) begin
                        s_d.dlo = data_rdata_i;
                    end else begin
                        s_d.dlo = ZERO_BYTE;
                    end
                    s_d.ctl.read_go = 1'b0;
                    s_d.rd = 1'b0;
                    s_d.st = ST_IDLE;
                end
            end
            ST_WRITE: begin
                // Self-timed; pump only for real, permitted locations
                s_d.pump = (s_q.ctl.program_space_select || data_hit(s_q.alo))
                           && wr_allowed;
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt == WR_LAST) begin
                    s_d.ctl.write_go = 1'b0;
                    s_d.done = 1'b1;
                    s_d.pump = 1'b0;
                    s_d.st = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // Pin/watchdog reset mid-write: abort, keep address and data
        if (ext_reset_i) begin
            if (s_q.st == ST_WRITE) begin
                s_d.abort = 1'b1;
            end
            s_d.st = ST_IDLE;
            s_d.ul = UL_NONE;
            s_d.pump = 1'b0;
            s_d.rd = 1'b0;
            s_d.ctl = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; power-on reset clears write-allow
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register, except the constant unlock byte
    assign nvm_data_low_o     = s_q.dlo;
    assign nvm_data_high_o    = s_q.dhi;
    assign nvm_addr_low_o     = s_q.alo;
    assign nvm_addr_high_o    = s_q.ahi;
    assign nvm_control_o      = {s_q.ctl.program_space_select, 2'b00, s_q.ctl.erase_select,
                                 s_q.abort, s_q.ctl.write_allow, s_q.ctl.write_go,
                                 s_q.ctl.read_go};
    assign nvm_unlock_o       = ZERO_BYTE;
    assign write_done_flag_o  = s_q.done;
    assign write_abort_flag_o = s_q.abort;
    assign pump_on_o          = s_q.pump;
    assign array_rd_o         = s_q.rd;
    assign prog_grant_o       = s_q.grant;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_read_clears: assert property (@(posedge clk_i) disable iff (srst_i || ext_reset_i)
        $rose(s_q.ctl.read_go) |-> ##[1:3] !s_q.ctl.read_go)
        else $error("read trigger not cleared in time");
    chk_write_lock: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(s_q.ctl.write_go) |-> $past(s_q.ul) == UL_OPEN)
        else $error("write started without unlock");
    chk_write_allow: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(s_q.ctl.write_go) |-> s_q.ctl.write_allow && $past(s_q.ctl.write_allow))
        else $error("write started without allow");
    chk_done_set: assert property (@(posedge clk_i) disable iff (srst_i || ext_reset_i)
        $fell(s_q.ctl.write_go) && !$past(ext_reset_i) |-> s_q.done)
        else $error("done flag not set");
    chk_hole_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(s_q.ctl.read_go) && !s_q.ctl.program_space_select && !data_hit(s_q.alo)
        && !$past(ext_reset_i) |-> s_q.dlo == ZERO_BYTE)
        else $error("hole did not read zero");
    chk_pump_hole: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.st == ST_WRITE && !s_q.ctl.program_space_select && !data_hit(s_q.alo)
        |=> !s_q.pump)
        else $error("pump on for hole");
    chk_abort_set: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.st == ST_WRITE && ext_reset_i |=> s_q.abort && s_q.st == ST_IDLE)
        else $error("abort flag not set");
    chk_grant_prot: assert property (@(posedge clk_i) disable iff (srst_i)
        code_protect_i |=> !s_q.grant)
        else $error("programmer granted under protection");
    chk_unlock_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        sw_i.unlock_we |=> nvm_unlock_o == ZERO_BYTE)
        else $error("unlock register not zero");
    // Registers hold still while a write runs, and through an abort of it
    chk_regs_hold: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.st == ST_WRITE |=> $stable(s_q.alo) && $stable(s_q.ahi)
                               && $stable(s_q.dlo) && $stable(s_q.dhi))
        else $error("address or data changed during write");
    // Sticky flags stay up until software clears them
    chk_done_sticky: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.done && !flag_clear_i |=> s_q.done)
        else $error("done flag dropped without clear");
    chk_abort_sticky: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.abort && !abort_clear_i |=> s_q.abort)
        else $error("abort flag dropped without clear");
    // Pump runs only under a live write trigger
    chk_pump_write: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.pump |-> s_q.ctl.write_go && s_q.st == ST_WRITE)
        else $error("pump on outside a write");
    // Self timer never runs past its end count
    chk_write_time: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.st == ST_WRITE |-> s_q.cnt <= WR_LAST)
        else $error("write timer overran");
    // Read data lands from the array in the final read cycle
    chk_read_data: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.st == ST_READ && s_q.cnt == RD_LAST && !ext_reset_i
        && !s_q.ctl.program_space_select && data_hit(s_q.alo)
        |=> s_q.dlo == $past(data_rdata_i))
        else $error("data byte not loaded");
    chk_prog_word: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.st == ST_READ && s_q.cnt == RD_LAST && !ext_reset_i
        && s_q.ctl.program_space_select
        |=> {s_q.dhi[PROG_W-DATA_W-1:0], s_q.dlo} == $past(prog_rdata_i))
        else $error("program word not loaded");
    // Upper data byte never shows bits above the word
    chk_high_mask: assert property (@(posedge clk_i) disable iff (srst_i)
        s_q.dhi[DATA_W-1:PROG_W-DATA_W] == '0)
        else $error("high data byte carries stray bits");
    // Reset leaves data space selected and writes disallowed
    chk_reset_state: assert property (@(posedge clk_i) disable iff (srst_i)
        $past(srst_i) |-> !s_q.ctl.program_space_select && !s_q.ctl.write_allow)
        else $error("control not cleared by reset");
    cov_read: cover property (@(posedge clk_i) $fell(s_q.ctl.read_go));
    cov_write: cover property (@(posedge clk_i) $fell(s_q.ctl.write_go) && s_q.done);
    cov_abort: cover property (@(posedge clk_i) $rose(s_q.abort));
    cov_prog_read: cover property (@(posedge clk_i)
        $fell(s_q.ctl.read_go) && s_q.ctl.program_space_select);
endmodule
`default_nettype wire

//--- dv/nvm_array_model.sv
// Behavioural model of the data and program arrays behind the controller
`timescale 1ns/10ps
`default_nettype none
module nvm_array_model
    import nvm_pkg::*;
#(
    parameter int PROG_WORDS = 1024          // Implemented program words
) (
    input  wire logic                 clk_i,
    input  wire logic                 array_rd_i,   // Read strobe level
    input  wire logic [DATA_W-1:0]    addr_low_i,
    input  wire logic [DATA_W-1:0]    addr_high_i,
    input  wire logic                 space_i,      // High selects program array
    output logic      [PROG_W-1:0]    prog_rdata_o,
    output logic      [DATA_W-1:0]    data_rdata_o
);
    logic [7:0]         junk_q = 8'h00;          // Churning idle pattern
    logic [PADDR_W-1:0] word_a;                  // Wrapped word address

    ////////////////////////////////////////////////////////////////////////
    // Idle bus never holds the last value, so a late sample shows up
    always_ff @(posedge clk_i) begin
        junk_q <= junk_q + 8'h3b;
    end

    // Word address folds onto the implemented array
    assign word_a = PADDR_W'({addr_high_i[4:0], addr_low_i} % PROG_WORDS);

    // Array contents are a fixed function of the address
    always_comb begin
        if (array_rd_i && !space_i) begin
            prog_rdata_o = {~junk_q[5:0], junk_q};
            data_rdata_o = addr_low_i ^ 8'h5a;
        end else if (array_rd_i) begin
            prog_rdata_o = {word_a[5:0], word_a[7:0]} ^ 14'h2a5a;
            data_rdata_o = ~junk_q;
        end else begin
            prog_rdata_o = {junk_q[5:0], ~junk_q};
            data_rdata_o = junk_q;
        end
    end
endmodule
`default_nettype wire

//--- dv/nvm_self_access_controller_tb.sv
// Self-checking bench for the nonvolatile self-access controller
`timescale 1ns/10ps
`default_nettype none
module nvm_self_access_controller_tb;
    import nvm_pkg::*;
    localparam int TICKS = 5;                    // Short write time for simulation
    localparam int PW    = 1024;                 // Program words of this variant
    localparam int AL = 13, AH = 12, DL = 11, UN = 9, CT = 8; // Strobe bits
    logic              clk_i = 1'b0;
    logic              srst_i = 1'b1;
    logic              ext_reset_i = 1'b0;
    sw_write_s         sw_i = '0;
    logic              flag_clear_i = 1'b0;
    logic              abort_clear_i = 1'b0;
    logic              code_protect_i = 1'b0;
    logic              prog_access_i = 1'b0;
    logic [7:0]        blk_prot = 8'h00;
    logic [PROG_W-1:0] prog_rdata;
    logic [DATA_W-1:0] data_rdata, d_lo, d_hi, a_lo, a_hi, ctrl, unl;
    logic              done_f, abort_f, pump, rd, grant;
    int                err_total = 0;
    int                cmp_count = 0;
    int                cyc = 0;
    int                seed = 91390;
    logic [12:0]       a;

    nvm_self_access_controller #(.DATA_BYTES(128), .PROG_WORDS(PW), .WRITE_TICKS(TICKS)) i_dut (
        .clk_i(clk_i), .srst_i(srst_i), .ext_reset_i(ext_reset_i), .sw_i(sw_i),
        .flag_clear_i(flag_clear_i), .abort_clear_i(abort_clear_i),
        .code_protect_i(code_protect_i), .block_protect_i(blk_prot),
        .prog_access_i(prog_access_i), .prog_rdata_i(prog_rdata), .data_rdata_i(data_rdata),
        .nvm_data_low_o(d_lo), .nvm_data_high_o(d_hi), .nvm_addr_low_o(a_lo),
        .nvm_addr_high_o(a_hi), .nvm_control_o(ctrl), .nvm_unlock_o(unl),
        .write_done_flag_o(done_f), .write_abort_flag_o(abort_f), .pump_on_o(pump),
        .array_rd_o(rd), .prog_grant_o(grant));
    nvm_array_model #(.PROG_WORDS(PW)) i_array (
        .clk_i(clk_i), .array_rd_i(rd), .addr_low_i(a_lo), .addr_high_i(a_hi),
        .space_i(ctrl[7]), .prog_rdata_o(prog_rdata), .data_rdata_o(data_rdata));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    // Expected program word; wrap folds high addresses onto the array
    function automatic logic [13:0] exp_word(input logic [12:0] adr);
        logic [12:0] w;
        w = adr % 13'(PW);
        return {w[5:0], w[7:0]} ^ 14'h2a5a;
    endfunction
    // One strobe; a spare edge follows so unlock pairs stay adjacent
    task automatic sw_wr(input int idx, input logic [7:0] v);
        sw_write_s s;
        s = '0;
        s.wdata = v;
        s[idx] = 1'b1;
        @(posedge clk_i);
        sw_i <= s;
        @(posedge clk_i);
        sw_i <= '0;
    endtask
    // Bounded wait for a self-clearing trigger bit
    task automatic wait_clear(input int bitn);
        for (int i = 0; i < 4 * TICKS && ctrl[bitn] !== 1'b0; i++) begin
            @(posedge clk_i);
            #1;
        end
    endtask
    task automatic rd_op(input logic pss);
        sw_wr(CT, {pss, 7'h01});
        @(posedge clk_i);
        #1;
        wait_clear(0);
    endtask
    task automatic arm_write(input logic pss);
        sw_wr(CT, {pss, 7'h04});
        sw_wr(UN, KEY_FIRST);
        sw_wr(UN, KEY_SECOND);
        sw_wr(CT, {pss, 7'h06});
        @(posedge clk_i);
        #1;
    endtask
    task automatic pulse(input int which);
        @(posedge clk_i);
        if (which == 0) flag_clear_i <= 1'b1; else abort_clear_i <= 1'b1;
        @(posedge clk_i);
        flag_clear_i <= 1'b0;
        abort_clear_i <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        #1;
        chk({ctrl, unl}, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            a = 13'($random(seed));
            sw_wr(AL, a[7:0]);
            rd_op(1'b0);
            chk({8'h00, d_lo}, {8'h00, a[7] ? ZERO_BYTE : a[7:0] ^ 8'h5a});
        end
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 13'h0405 : 13'($random(seed));
            sw_wr(AH, {3'b000, a[12:8]});
            sw_wr(AL, a[7:0]);
            rd_op(1'b1);
            chk({d_hi, d_lo}, {2'b00, exp_word(a)});
        end
        // Trigger without the unlock pair is ignored
        sw_wr(AL, 8'h21);
        sw_wr(CT, 8'h04);
        sw_wr(CT, 8'h06);
        @(posedge clk_i);
        #1;
        chk_bit(ctrl[1] | pump, 1'b0);
        arm_write(1'b0);
        chk_bit(ctrl[1] & pump, 1'b1);
        sw_wr(CT, 8'h04);
        #1;
        chk_bit(ctrl[1], 1'b1);
        sw_wr(AL, 8'h33);
        #1;
        wait_clear(1);
        chk({13'h0, ctrl[1], pump, done_f}, 16'h0001);
        chk({8'h00, a_lo}, 16'h0021);
        repeat (3) @(posedge clk_i);
        #1;
        chk_bit(done_f, 1'b1);
        pulse(0);
        chk_bit(done_f, 1'b0);
        // Write to a hole keeps the pump off
        sw_wr(AL, 8'h90);
        arm_write(1'b0);
        chk_bit(pump, 1'b0);
        wait_clear(1);
        pulse(0);
        // Reset in mid-write
        sw_wr(AL, 8'h12);
        sw_wr(DL, 8'ha5);
        arm_write(1'b0);
        @(posedge clk_i);
        ext_reset_i <= 1'b1;
        @(posedge clk_i);
        ext_reset_i <= 1'b0;
        #1;
        chk({7'h0, abort_f, ctrl}, 16'h0108);
        chk({a_lo, d_lo}, 16'h12a5);
        pulse(1);
        chk_bit(abort_f, 1'b0);
        sw_wr(UN, KEY_FIRST);
        sw_wr(UN, KEY_SECOND);
        sw_wr(CT, 8'h06);
        @(posedge clk_i);
        #1;
        chk_bit(ctrl[1] | pump, 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            {code_protect_i, prog_access_i} <= 2'(i);
            repeat (2) @(posedge clk_i);
            #1;
            chk_bit(grant, i == 1);
        end
        rd_op(1'b0);
        chk({8'h00, d_lo}, 16'h0048);
        // Protected region: alias 405h wraps onto region 0 and stays unpowered
        @(posedge clk_i);
        blk_prot <= 8'h01;
        sw_wr(AH, 8'h04);
        sw_wr(AL, 8'h05);
        arm_write(1'b1);
        chk_bit(pump, 1'b0);
        wait_clear(1);
        sw_wr(AH, 8'h01);
        arm_write(1'b1);
        chk_bit(pump, 1'b1);
        wait_clear(1);
        pulse(0);
        chk_bit(done_f, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
